// ==== core/stf_map.vh ====
// stf_map.vh: constants of the switch telegram framer
// assumes: included by the framer core files and the bench, by its bare name
`ifndef STF_MAP_VH
`define STF_MAP_VH

// register word indexes on the plain register port
`define STF_REG_CTRL      4'h0
`define STF_REG_MFR       4'h1
`define STF_REG_OPT       4'h2
`define STF_REG_SADDR_LO  4'h3
`define STF_REG_SADDR_HI  4'h4
`define STF_REG_KEY0      4'h5
`define STF_REG_IRK0      4'h9
`define STF_REG_SEQ       4'hd
`define STF_REG_STATUS    4'he
`define STF_REG_ADDR_LO   4'hf

// control register fields
`define STF_CTRL_PRIV     0
`define STF_CTRL_OSZ_LO   1
`define STF_CTRL_OSZ_HI   2
`define STF_PRIV_ON       1'b1

// payload constants
`define STF_TYPE_MSD      8'hff
`define STF_LEN_BASE      8'h0c
`define STF_LEN_COMM      8'h1d
`define STF_PLEN_COMM     5'd30
`define STF_OFS_SEQ       5'd4
`define STF_OFS_STAT      5'd8
`define STF_OFS_OPT       5'd9
`define STF_OFS_KEY       5'd8
`define STF_OFS_SADDR     5'd24
`define STF_SIG_BYTES     5'd4
`define STF_PRAND_TOP     2'b10

// frame constants
`define STF_HDR0          8'h42
`define STF_HDR_BYTES     6'd2
`define STF_ADDR_BYTES    8'h06
`define STF_PAY_START     6'd8
`define STF_CRC_BYTES     6'd3
`define STF_CRC_INIT      24'h555555
`define STF_CRC_POLY      24'hda6000

`endif

// ==== core/stf_crc24.v ====
// stf_crc24.v: byte-wide 24-bit frame check accumulator
// assumes: bytes enter least significant bit first, one per enable
`timescale 1ns/10ps
`include "stf_map.vh"

module stf_crc24 (
	input  wire        clk,      // system clock
	input  wire        rst,      // synchronous reset, active high
	input  wire        init,     // reload the seed value
	input  wire        en,       // fold one byte in
	input  wire [7:0]  din,      // byte to fold
	output reg  [23:0] crc_ff    // running check value
);
	reg [23:0] nxt_crc; // value after folding din
	integer    i;       // bit walker

	// reflected form: result byte 0 goes out first
	always @* begin
		nxt_crc = crc_ff;
		for (i = 0; i < 8; i = i + 1) begin
			if (nxt_crc[0] ^ din[i])
				nxt_crc = (nxt_crc >> 1) ^ `STF_CRC_POLY;
			else
				nxt_crc = nxt_crc >> 1;
		end
	end

	// init has priority over folding
	always @(posedge clk) begin
		if (rst || init)
			crc_ff <= `STF_CRC_INIT;
		else if (en)
			crc_ff <= nxt_crc;
	end
endmodule // stf_crc24

// ==== core/stf_pbuf.v ====
// stf_pbuf.v: payload byte store with registered read
// assumes: one writer and one reader on the same clock
`timescale 1ns/10ps

module stf_pbuf #(
	parameter AW = 5, // address width
	parameter DW = 8  // data width
) (
	input  wire          clk,     // system clock
	input  wire          we,      // write enable
	input  wire [AW-1:0] waddr,   // write address
	input  wire [DW-1:0] wdata,   // write data
	input  wire [AW-1:0] raddr,   // read address
	output reg  [DW-1:0] rdata_ff // read data, one cycle after raddr
);
	reg [DW-1:0] mem [0:(1<<AW)-1]; // payload bytes

	// contents need no reset: every byte is written before it is read
	always @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		rdata_ff <= mem[raddr];
	end
endmodule // stf_pbuf

// ==== core/stf_framer.v ====
// stf_framer.v: telegram framer of a self-powered pushbutton transmitter
// assumes: cipher engine outside answers each request with one done pulse,
// the radio takes frame bytes over a valid/ready stream, start strobes
// come from logic on this clock, direction and contact pins do not
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "stf_map.vh"

// Functional notes
// - private flag set selects rotating private address
// - new private address per push and release
// - random part top two bits are 10
// - random part held for whole telegram
// - hash is low 24 bits of encryption
// - address is random part over hash
// - resolution key defaults to device key, writable
// - commissioning telegrams use static address
// - three byte check over header, address, payload
// - data length 0x0c/0x0d/0x0e/0x10 by option size
// - data type byte is 0xff
// - two byte maker identifier, writable
// - sequence counter inserted, then incremented per telegram
// - data payload field order, 13 to 17 bytes
// - direction, contacts, payload, then signature
// - bit 0 action, other bits actuated contacts
// - commissioning payload 30 bytes, length 0x1d
// - commissioning type byte is 0xff
// - commissioning carries full 16 byte key
// - commissioning ends with static address
// - nonce: address, counter, three zero bytes
module stf_framer #(
	parameter         NCON     = 4,              // button contacts
	parameter [15:0]  MFR_DEF  = 16'h1234,       // arbitrary maker code
	parameter [47:0]  SADR_DEF = 48'h5a5a00000001, // arbitrary static address
	parameter [127:0] KEY_DEF  = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0 // arbitrary key
) (
	input  wire         CLK_SYS,    // system clock, 50 MHz
	input  wire         RST,        // synchronous reset, active high
	input  wire [3:0]   REG_ADDR,   // register word index
	input  wire [31:0]  REG_WDATA,  // register write data
	input  wire         REG_WR,     // write strobe
	input  wire         REG_RD,     // read strobe
	output reg  [31:0]  REG_RDATA,  // read data, cycle after the strobe
	input  wire         ACT_START,  // button action detected
	input  wire         ACT_DIR,    // pin: 1 push, 0 release
	input  wire [NCON-1:0] CONTACT, // pins: contact closed
	input  wire         COMM_START, // send a commissioning telegram
	output reg          CRY_REQ,    // cipher request pulse
	output reg          CRY_SIGN,   // 1 signature, 0 plain block cipher
	output reg  [127:0] CRY_KEY,    // cipher key
	output reg  [103:0] CRY_NONCE,  // signature nonce
	output reg  [127:0] CRY_DATA,   // block or authenticated payload
	input  wire [127:0] CRY_RESULT, // cipher result
	input  wire         CRY_DONE,   // result valid pulse
	output wire         TX_VALID,   // frame byte valid
	output reg  [7:0]   TX_DATA,    // frame byte
	output reg          TX_LAST,    // last byte of frame
	input  wire         TX_READY,   // radio takes the byte
	output wire         BUSY        // telegram in progress
);
	////////////////////////////////////////////////////////////////////////
	// states
	localparam S_IDLE  = 4'd0;  // waiting for an event
	localparam S_DIR   = 4'd1;  // latch action direction
	localparam S_SAMP  = 4'd2;  // latch contacts
	localparam S_HASH  = 4'd3;  // issue hash request
	localparam S_HWAIT = 4'd4;  // wait for hash
	localparam S_BUILD = 4'd5;  // write payload bytes
	localparam S_SIGN  = 4'd6;  // issue signature request
	localparam S_SWAIT = 4'd7;  // wait for signature
	localparam S_FETCH = 4'd8;  // buffer address settles
	localparam S_LOAD  = 4'd9;  // load output byte
	localparam S_PUT   = 4'd10; // byte offered to radio
	localparam S_DONE  = 4'd11; // bump the counter

	////////////////////////////////////////////////////////////////////////
	// configuration and state registers
	reg [3:0]      st_ff;        // framer state
	reg            priv_ff;      // private address mode flag
	reg [1:0]      osz_ff;       // option size code
	reg [15:0]     mfr_ff;       // maker identifier
	reg [31:0]     opt_ff;       // optional data
	reg [47:0]     sadr_ff;      // static address
	reg [127:0]    key_ff;       // device security key
	reg [127:0]    irk_ff;       // identity resolution key
	reg [31:0]     seq_ff;       // sequence counter
	reg            comm_ff;      // telegram is commissioning
	reg            dir_ff;       // 1 push, 0 release
	reg [NCON-1:0] con_ff;       // contacts in this action
	reg [23:0]     prand_ff;     // random address part
	reg [23:0]     hash_ff;      // address check part
	reg            useprv_ff;    // this telegram uses private address
	reg [31:0]     sig_ff;       // signature
	reg            sigok_ff;     // signature stored
	reg [4:0]      wptr_ff;      // payload write index
	reg [5:0]      pos_ff;       // frame byte index
	reg [21:0]     lfsr_ff;      // free running random source
	reg [NCON:0]   dsync_ff [0:1]; // pin synchroniser stages

	wire [NCON:0]  pins_s = dsync_ff[1];    // synchronised pins
	wire           dir_s  = pins_s[0];      // direction pin
	wire [NCON-1:0] con_s = pins_s[NCON:1]; // contact pins

	////////////////////////////////////////////////////////////////////////
	// derived payload figures
	reg  [2:0]  optn;   // optional bytes
	reg  [7:0]  len_b;  // length byte
	reg  [4:0]  plen;   // payload bytes
	wire [4:0]  sig_at = plen - `STF_SIG_BYTES; // first signature byte
	wire [47:0] tx_adr = useprv_ff ? {prand_ff, hash_ff} : sadr_ff;
	wire [7:0]  stat_b = {{(7-NCON){1'b0}}, con_ff, dir_ff};
	wire [5:0]  total  = `STF_PAY_START + {1'b0, plen} + `STF_CRC_BYTES; // frame bytes

	// option size code maps to 0, 1, 2 or 4 bytes
	always @* begin
		case (osz_ff)
			2'd0:    optn = 3'd0;
			2'd1:    optn = 3'd1;
			2'd2:    optn = 3'd2;
			default: optn = 3'd4;
		endcase
		if (comm_ff) begin
			len_b = `STF_LEN_COMM;
			plen  = `STF_PLEN_COMM;
		end else begin
			len_b = `STF_LEN_BASE + {5'd0, optn};
			plen  = len_b[4:0] + 5'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// payload byte for the write index
	reg  [7:0] pbyte;                        // byte to store
	wire [4:0] ki = wptr_ff - `STF_OFS_KEY;   // key byte index
	wire [4:0] ai = wptr_ff - `STF_OFS_SADDR; // address byte index
	wire [4:0] oi = wptr_ff - `STF_OFS_OPT;   // option byte index
	wire [4:0] gi = wptr_ff - sig_at;         // signature byte index

	// all multibyte fields go least significant byte first
	always @* begin
		if (wptr_ff == 5'd0)
			pbyte = len_b;
		else if (wptr_ff == 5'd1)
			pbyte = `STF_TYPE_MSD;
		else if (wptr_ff == 5'd2)
			pbyte = mfr_ff[7:0];
		else if (wptr_ff == 5'd3)
			pbyte = mfr_ff[15:8];
		else if (wptr_ff < `STF_OFS_STAT)
			pbyte = seq_ff[{wptr_ff[1:0], 3'b000} +: 8];
		else if (comm_ff) begin
			if (wptr_ff < `STF_OFS_SADDR)
				pbyte = key_ff[{ki[3:0], 3'b000} +: 8];
			else
				pbyte = sadr_ff[{ai[2:0], 3'b000} +: 8];
		end else if (wptr_ff == `STF_OFS_STAT)
			pbyte = stat_b;
		else if (wptr_ff < sig_at)
			pbyte = opt_ff[{oi[1:0], 3'b000} +: 8];
		else
			pbyte = sig_ff[{gi[1:0], 3'b000} +: 8];
	end

	////////////////////////////////////////////////////////////////////////
	// payload store and check accumulator
	wire        pwe  = (st_ff == S_BUILD); // store while building
	wire [7:0]  rbyte;                     // payload byte read back
	wire [23:0] crc;                       // running check value
	wire [5:0]  ridx = pos_ff - `STF_PAY_START; // payload read index
	wire        take = TX_VALID && TX_READY;   // radio took a byte
	wire        in_body = pos_ff < (`STF_PAY_START + {1'b0, plen}); // before check

	stf_pbuf #(.AW(5), .DW(8)) u_pbuf (
		.clk      (CLK_SYS),
		.we       (pwe),
		.waddr    (wptr_ff),
		.wdata    (pbyte),
		.raddr    (ridx[4:0]),
		.rdata_ff (rbyte)
	);

	// check covers header, address and payload only
	stf_crc24 u_crc (
		.clk    (CLK_SYS),
		.rst    (RST),
		.init   (st_ff == S_BUILD),
		.en     (take && in_body),
		.din    (TX_DATA),
		.crc_ff (crc)
	);

	////////////////////////////////////////////////////////////////////////
	// frame byte selection
	reg  [7:0] fbyte;                               // byte for pos_ff
	wire [5:0] fi = pos_ff - `STF_HDR_BYTES;        // address byte index
	wire [5:0] ci = pos_ff - `STF_PAY_START - {1'b0, plen}; // check byte index

	// header, address, payload from store, then check bytes
	always @* begin
		if (pos_ff == 6'd0)
			fbyte = `STF_HDR0;
		else if (pos_ff == 6'd1)
			fbyte = `STF_ADDR_BYTES + {3'd0, plen};
		else if (pos_ff < `STF_PAY_START)
			fbyte = tx_adr[{fi[2:0], 3'b000} +: 8];
		else if (in_body)
			fbyte = rbyte;
		else
			fbyte = crc[{ci[1:0], 3'b000} +: 8];
	end

	assign TX_VALID = (st_ff == S_PUT);
	assign BUSY     = (st_ff != S_IDLE);

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser and random source
	// the random source runs every cycle, so button timing seeds it
	always @(posedge CLK_SYS) begin
		if (RST) begin
			dsync_ff[0] <= {(NCON+1){1'b0}};
			dsync_ff[1] <= {(NCON+1){1'b0}};
			lfsr_ff     <= 22'h000001;
		end else begin
			dsync_ff[0] <= {CONTACT, ACT_DIR};
			dsync_ff[1] <= dsync_ff[0];
			lfsr_ff     <= {lfsr_ff[20:0], lfsr_ff[21] ^ lfsr_ff[20]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// telegram sequencer
	always @(posedge CLK_SYS) begin
		if (RST) begin
			st_ff     <= S_IDLE;
			comm_ff   <= 1'b0;
			dir_ff    <= 1'b0;
			con_ff    <= {NCON{1'b0}};
			prand_ff  <= 24'h000000;
			hash_ff   <= 24'h000000;
			useprv_ff <= 1'b0;
			sig_ff    <= 32'h00000000;
			sigok_ff  <= 1'b0;
			wptr_ff   <= 5'd0;
			pos_ff    <= 6'd0;
			seq_ff    <= 32'h00000000;
			CRY_REQ   <= 1'b0;
			CRY_SIGN  <= 1'b0;
			CRY_KEY   <= 128'h0;
			CRY_NONCE <= 104'h0;
			CRY_DATA  <= 128'h0;
			TX_DATA   <= 8'h00;
			TX_LAST   <= 1'b0;
		end else begin
			CRY_REQ <= 1'b0;
			case (st_ff)
				S_IDLE: begin
					wptr_ff  <= 5'd0;
					sigok_ff <= 1'b0;
					// an action wins over a commissioning request
					if (ACT_START) begin
						comm_ff <= 1'b0;
						st_ff   <= S_DIR;
					end else if (COMM_START) begin
						comm_ff   <= 1'b1;
						useprv_ff <= 1'b0;
						st_ff     <= S_BUILD;
					end
				end
				S_DIR: begin
					dir_ff <= dir_s;
					st_ff  <= S_SAMP;
				end
				S_SAMP: begin
					con_ff    <= con_s;
					useprv_ff <= (priv_ff == `STF_PRIV_ON);
					if (priv_ff == `STF_PRIV_ON) begin
						prand_ff <= {`STF_PRAND_TOP, lfsr_ff};
						st_ff    <= S_HASH;
					end else
						st_ff <= S_BUILD;
				end
				S_HASH: begin
					CRY_REQ  <= 1'b1;
					CRY_SIGN <= 1'b0;
					CRY_KEY  <= irk_ff;
					CRY_DATA <= {104'h0, prand_ff};
					st_ff    <= S_HWAIT;
				end
				S_HWAIT: begin
					if (CRY_DONE) begin
						hash_ff <= CRY_RESULT[23:0];
						st_ff   <= S_BUILD;
					end
				end
				S_BUILD: begin
					// stop before the signature until it is known
					if (!comm_ff && !sigok_ff && wptr_ff == sig_at)
						st_ff <= S_SIGN;
					else if (wptr_ff == plen - 5'd1) begin
						pos_ff <= 6'd0;
						st_ff  <= S_FETCH;
					end else
						wptr_ff <= wptr_ff + 5'd1;
				end
				S_SIGN: begin
					CRY_REQ   <= 1'b1;
					CRY_SIGN  <= 1'b1;
					CRY_KEY   <= key_ff;
					CRY_NONCE <= {24'h000000, seq_ff, tx_adr};
					CRY_DATA  <= {24'h0, opt_ff, stat_b, seq_ff, mfr_ff,
						`STF_TYPE_MSD, len_b};
					st_ff     <= S_SWAIT;
				end
				S_SWAIT: begin
					if (CRY_DONE) begin
						sig_ff   <= CRY_RESULT[31:0];
						sigok_ff <= 1'b1;
						st_ff    <= S_BUILD;
					end
				end
				S_FETCH: st_ff <= S_LOAD; // store read settles
				S_LOAD: begin
					TX_DATA <= fbyte;
					TX_LAST <= (pos_ff == total - 6'd1);
					st_ff   <= S_PUT;
				end
				S_PUT: begin
					// address parts stay frozen until the frame ends
					if (TX_READY) begin
						if (TX_LAST)
							st_ff <= S_DONE;
						else begin
							pos_ff <= pos_ff + 6'd1;
							st_ff  <= S_FETCH;
						end
					end
				end
				S_DONE: begin
					seq_ff  <= seq_ff + 32'd1;
					TX_LAST <= 1'b0;
					st_ff   <= S_IDLE;
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes
	// keys are four words, lowest word at the lowest index
	wire [3:0] kw = REG_ADDR - `STF_REG_KEY0; // key word select
	wire [3:0] iw = REG_ADDR - `STF_REG_IRK0; // resolution key word select

	always @(posedge CLK_SYS) begin
		if (RST) begin
			priv_ff <= 1'b0;
			osz_ff  <= 2'd0;
			mfr_ff  <= MFR_DEF;
			opt_ff  <= 32'h00000000;
			sadr_ff <= SADR_DEF;
			key_ff  <= KEY_DEF;
			irk_ff  <= KEY_DEF;
		end else if (REG_WR) begin
			if (REG_ADDR == `STF_REG_CTRL) begin
				priv_ff <= REG_WDATA[`STF_CTRL_PRIV];
				osz_ff  <= REG_WDATA[`STF_CTRL_OSZ_HI:`STF_CTRL_OSZ_LO];
			end else if (REG_ADDR == `STF_REG_MFR)
				mfr_ff <= REG_WDATA[15:0];
			else if (REG_ADDR == `STF_REG_OPT)
				opt_ff <= REG_WDATA;
			else if (REG_ADDR == `STF_REG_SADDR_LO)
				sadr_ff[31:0] <= REG_WDATA;
			else if (REG_ADDR == `STF_REG_SADDR_HI)
				sadr_ff[47:32] <= REG_WDATA[15:0];
			else if (REG_ADDR >= `STF_REG_KEY0 && REG_ADDR < `STF_REG_IRK0)
				key_ff[{kw[1:0], 5'd0} +: 32] <= REG_WDATA;
			else if (REG_ADDR >= `STF_REG_IRK0 && REG_ADDR < `STF_REG_SEQ)
				irk_ff[{iw[1:0], 5'd0} +: 32] <= REG_WDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads, data in the cycle after the strobe
	// writes mid-telegram take effect at once; software should poll busy
	always @(posedge CLK_SYS) begin
		if (RST)
			REG_RDATA <= 32'h00000000;
		else if (REG_RD) begin
			case (REG_ADDR)
				`STF_REG_CTRL:     REG_RDATA <= {29'd0, osz_ff, priv_ff};
				`STF_REG_MFR:      REG_RDATA <= {16'd0, mfr_ff};
				`STF_REG_OPT:      REG_RDATA <= opt_ff;
				`STF_REG_SADDR_LO: REG_RDATA <= sadr_ff[31:0];
				`STF_REG_SADDR_HI: REG_RDATA <= {16'd0, sadr_ff[47:32]};
				`STF_REG_SEQ:      REG_RDATA <= seq_ff;
				`STF_REG_STATUS:   REG_RDATA <= {27'd0, useprv_ff, st_ff};
				`STF_REG_ADDR_LO:  REG_RDATA <= tx_adr[31:0];
				default:           REG_RDATA <= 32'h00000000; // keys read as zero
			endcase
		end else
			REG_RDATA <= 32'h00000000;
	end
endmodule // stf_framer

// ==== bench/stf_framer_sva.sv ====
// stf_framer_sva.sv: port checker for the telegram framer
// assumes: bound to stf_framer, sees only its ports, one clock
`timescale 1ns/10ps
module stf_framer_sva (
	input wire         CLK_SYS,
	input wire         RST,
	input wire         ACT_START,
	input wire         COMM_START,
	input wire         BUSY,
	input wire         CRY_REQ,
	input wire         CRY_SIGN,
	input wire [103:0] CRY_NONCE,
	input wire [127:0] CRY_DATA,
	input wire [127:0] CRY_RESULT,
	input wire         CRY_DONE,
	input wire         TX_VALID,
	input wire [7:0]   TX_DATA,
	input wire         TX_LAST,
	input wire         TX_READY
);
default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (RST);
////////////////////////////////////////
reg        pend_ff;  // hash request outstanding
reg        have_ff;  // hash known for the coming signature
reg [23:0] prand_ff; // low data bits of the last cipher request, hash or signature
reg [23:0] hash_ff;  // low bits of the last hash answer
// remember the last hash so the signature nonce can be tied to it
always @(posedge CLK_SYS) begin
	if (RST) begin
		pend_ff <= 1'b0;
		have_ff <= 1'b0;
	end else if (CRY_REQ) begin
		pend_ff <= !CRY_SIGN;
		have_ff <= 1'b0;
		prand_ff <= CRY_DATA[23:0];
	end else if (CRY_DONE && pend_ff) begin
		pend_ff <= 1'b0;
		have_ff <= 1'b1;
		hash_ff <= CRY_RESULT[23:0];
	end
end
////////////////////////////////////////
prand_top_a: assert property (CRY_REQ && !CRY_SIGN |-> CRY_DATA[23:22] == 2'b10)
	else $error("prand top bits");
addr_join_a: assert property (CRY_REQ && CRY_SIGN && have_ff |->
	CRY_NONCE[47:0] == {prand_ff, hash_ff}) else $error("addr not prand:hash");
nonce_pad_a: assert property (CRY_REQ && CRY_SIGN |-> CRY_NONCE[103:80] == 24'h0)
	else $error("nonce pad");
sign_type_a: assert property (CRY_REQ && CRY_SIGN |-> CRY_DATA[15:8] == 8'hff)
	else $error("type byte");
len_code_a: assert property (CRY_REQ && CRY_SIGN |->
	CRY_DATA[7:0] inside {8'h0c, 8'h0d, 8'h0e, 8'h10}) else $error("length byte");
cry_hold_a: assert property (!CRY_REQ |-> $stable(CRY_DATA) && $stable(CRY_NONCE))
	else $error("cipher inputs moved");
req_pulse_a: assert property (CRY_REQ |=> !CRY_REQ)
	else $error("long cipher request");
tx_hold_a: assert property (TX_VALID && !TX_READY |=>
	TX_VALID && $stable(TX_DATA) && $stable(TX_LAST)) else $error("stalled byte moved");
start_busy_a: assert property (!BUSY && (ACT_START || COMM_START) |=> BUSY)
	else $error("start not taken");
frame_end_a: assert property (TX_VALID && TX_READY && TX_LAST |-> ##[1:2] !BUSY)
	else $error("busy after end");
tx_busy_a: assert property (TX_VALID |-> BUSY)
	else $error("byte while idle");
// main scenarios reached
c_hash: cover property (CRY_REQ && !CRY_SIGN);
c_stall: cover property (TX_VALID && !TX_READY);
c_last: cover property (TX_VALID && TX_READY && TX_LAST);
endmodule // stf_framer_sva

// ==== bench/stf_rx_model.sv ====
// stf_rx_model.sv: radio receiver and cipher stand-in for the framer
// assumes: same clock as the framer; cipher answer is key xor data
`timescale 1ns/10ps
module stf_rx_model (
	input  wire         clk,
	input  wire         rst,
	input  wire         slow,       // stall radio and cipher
	input  wire         tx_valid,
	input  wire [7:0]   tx_data,
	input  wire         tx_last,
	output reg          tx_ready,
	input  wire         cry_req,
	input  wire [127:0] cry_key,
	input  wire [127:0] cry_data,
	output reg  [127:0] cry_result,
	output reg          cry_done
);
reg [7:0]   buf_ff [0:63]; // bytes of the latest frame
reg [127:0] ans_ff;        // pending cipher answer
integer     nb;            // bytes taken in this frame
integer     flen;          // length of the last whole frame
integer     frames;        // whole frames seen
integer     cyc;           // free count for the stall pattern
integer     wait_n;        // cycles to the answer, -1 idle
// radio side: take bytes, close a frame on the last flag
always @(posedge clk) begin
	cyc <= cyc + 1;
	if (rst) begin
		tx_ready <= 1'b0;
		nb <= 0;
		frames <= 0;
		cyc <= 0;
	end else begin
		tx_ready <= slow ? (cyc % 3 == 0) : 1'b1;
		if (tx_valid && tx_ready) begin
			buf_ff[nb] <= tx_data;
			nb <= tx_last ? 0 : nb + 1;
			if (tx_last) begin
				flen <= nb + 1;
				frames <= frames + 1;
			end
		end
	end
end
// cipher side: stale result is inverted so it never looks valid
always @(posedge clk) begin
	if (rst) begin
		cry_done <= 1'b0;
		cry_result <= 128'h0;
		wait_n <= -1;
	end else begin
		cry_done <= (wait_n == 0);
		cry_result <= (wait_n == 0) ? ans_ff : ~ans_ff;
		if (wait_n >= 0)
			wait_n <= wait_n - 1;
		if (cry_req) begin
			wait_n <= slow ? 5 : 1;
			ans_ff <= cry_key ^ cry_data;
		end
	end
end
endmodule // stf_rx_model

// ==== bench/tb_stf_framer.sv ====
// tb_stf_framer.sv: self-checking bench of the telegram framer
// assumes: stf_map.vh on the include path, checker bound below
`timescale 1ns/10ps
`include "stf_map.vh"
module tb_stf_framer;
localparam [15:0]  MFR  = 16'h5c71;         // arbitrary maker code
localparam [47:0]  SADR = 48'h4a3b2c1d0e9f; // arbitrary static address
localparam [127:0] KEY  = 128'h00112233445566778899aabbccddeeff; // arbitrary
localparam [127:0] IRK2 = 128'h8899aabbccddeeff0123456789abcdef; // arbitrary
reg CLK_SYS = 1'b0;
reg RST = 1'b1;
reg [3:0] REG_ADDR = 4'h0;
reg [31:0] REG_WDATA = 32'h0;
reg REG_WR = 1'b0, REG_RD = 1'b0, ACT_START = 1'b0, ACT_DIR = 1'b0;
reg [3:0] CONTACT = 4'h0;
reg COMM_START = 1'b0;
reg slow = 1'b0;
wire [31:0] REG_RDATA;
wire CRY_REQ, CRY_SIGN, CRY_DONE, TX_VALID, TX_LAST, TX_READY, BUSY;
wire [127:0] CRY_KEY, CRY_DATA, CRY_RESULT;
wire [103:0] CRY_NONCE;
wire [7:0] TX_DATA;
integer mismatches = 0;
integer checked = 0;
integer en;             // bytes in the expected frame
reg [7:0] ex [0:63];    // expected frame
reg [31:0] seq = 0;     // expected sequence count
reg [15:0] mfr = MFR;   // expected maker code
reg [127:0] h_key, h_data, s_key; // seen at cipher requests
reg [103:0] s_nonce;
always #10 CLK_SYS = ~CLK_SYS;
stf_framer #(.MFR_DEF(MFR), .SADR_DEF(SADR), .KEY_DEF(KEY)) uut (.*);
stf_rx_model rx (.clk(CLK_SYS), .rst(RST), .slow(slow), .tx_valid(TX_VALID),
	.tx_data(TX_DATA), .tx_last(TX_LAST), .tx_ready(TX_READY), .cry_req(CRY_REQ),
	.cry_key(CRY_KEY), .cry_data(CRY_DATA), .cry_result(CRY_RESULT), .cry_done(CRY_DONE));
// snapshot cipher inputs at each request
always @(posedge CLK_SYS) begin
	if (CRY_REQ && CRY_SIGN) begin
		s_key <= CRY_KEY;
		s_nonce <= CRY_NONCE;
	end else if (CRY_REQ) begin
		h_key <= CRY_KEY;
		h_data <= CRY_DATA;
	end
end
////////////////////////////////////////
task chk(input [127:0] got, input [127:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	end
endtask
task reg_wr(input [3:0] a, input [31:0] d);
	begin
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	end
endtask
// read data stand only in the cycle after the strobe
task reg_rd(input [3:0] a, output [31:0] d);
	begin
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	end
endtask
task put_n(input [127:0] v, input integer n);
	integer i;
	begin
		for (i = 0; i < n; i++) begin
			ex[en] = v[8*i +: 8];
			en = en + 1;
		end
	end
endtask
task hdr(input [47:0] a, input [7:0] plen);
	begin
		en = 0;
		put_n({plen + 8'h06, `STF_HDR0}, 2);
		put_n(a, 6);
	end
endtask
// close the expected frame with its check bytes and compare
task check_frame;
	reg [23:0] c;
	integer i, j;
	begin
		c = `STF_CRC_INIT;
		for (i = 0; i < en; i++)
			for (j = 0; j < 8; j++)
				c = (c[0] ^ ex[i][j]) ? ((c >> 1) ^ `STF_CRC_POLY) : (c >> 1);
		put_n(c, 3);
		chk(rx.flen, en);
		for (i = 0; i < en; i++)
			chk(rx.buf_ff[i], ex[i]);
		seq = seq + 1;
	end
endtask
// start pulse; commissioning adds a stray start while busy
task send(input comm);
	integer f, n;
	begin
		f = rx.frames;
		@(posedge CLK_SYS);
		if (comm) COMM_START <= 1'b1;
		else ACT_START <= 1'b1;
		@(posedge CLK_SYS);
		COMM_START <= 1'b0;
		ACT_START <= comm;
		n = 0;
		while (rx.frames == f && n < 5000) begin
			@(posedge CLK_SYS);
			ACT_START <= 1'b0;
			n = n + 1;
		end
		repeat (3) @(posedge CLK_SYS);
		chk(rx.frames - f, 1);
	end
endtask
////////////////////////////////////////
task t_regs;
	reg [31:0] d;
	begin
		reg_rd(`STF_REG_MFR, d);
		chk(d[15:0], MFR);
		reg_rd(`STF_REG_SEQ, d);
		chk(d, 32'h0);
		reg_rd(`STF_REG_KEY0, d);
		chk(d, 32'h0);
		mfr = 16'h9e01;
		reg_wr(`STF_REG_MFR, {16'h0, mfr});
		reg_rd(`STF_REG_MFR, d);
		chk(d[15:0], mfr);
	end
endtask
// static address, every option size, press and release, stalls
task t_data;
	integer k, no;
	reg [7:0] len;
	begin
		for (k = 0; k < 4; k++) begin
			no = (k == 3) ? 4 : k;
			len = 8'h0c + no;
			reg_wr(`STF_REG_CTRL, k << 1);
			reg_wr(`STF_REG_OPT, 32'ha1b2c3d4);
			ACT_DIR <= (k != 1);
			CONTACT <= k + 1;
			slow <= k[0];
			repeat (4) @(posedge CLK_SYS);
			send(0);
			hdr(SADR, len + 1);
			put_n({seq, mfr, 8'hff, len}, 8);
			put_n({3'b000, 4'(k + 1), (k != 1)}, 1);
			put_n(32'ha1b2c3d4, no);
			put_n(KEY[31:0] ^ {mfr, 8'hff, len}, 4);
			chk(s_nonce, {24'h0, seq, SADR});
			chk(s_key, KEY);
			check_frame;
		end
	end
endtask
// private mode: default resolution key, then a replaced one
task t_priv;
	integer p, i;
	reg [23:0] pr, old;
	reg [127:0] key;
	begin
		reg_wr(`STF_REG_CTRL, {31'h0, `STF_PRIV_ON});
		for (p = 0; p < 2; p++) begin
			key = p ? IRK2 : KEY;
			if (p) for (i = 0; i < 4; i++) reg_wr(4'h9 + i, IRK2[32*i +: 32]);
			ACT_DIR <= (p == 0);
			CONTACT <= 4'h3;
			repeat (4) @(posedge CLK_SYS);
			old = pr;
			send(0);
			pr = h_data[23:0];
			chk(h_key, key);
			chk(h_data[23:22], 2'b10);
			if (p) chk(pr != old, 1);
			hdr({pr, pr ^ key[23:0]}, 8'h0d);
			put_n({seq, mfr, 8'hff, 8'h0c}, 8);
			put_n({3'b000, 4'h3, (p == 0)}, 1);
			put_n(KEY[31:0] ^ {mfr, 8'hff, 8'h0c}, 4);
			chk(s_nonce[47:0], {pr, pr ^ key[23:0]});
			check_frame;
		end
	end
endtask
// commissioning keeps the static address, stray start is dropped
task t_comm;
	reg [31:0] d;
	begin
		slow <= 1'b1;
		send(1);
		hdr(SADR, 8'd30);
		put_n({seq, mfr, 8'hff, `STF_LEN_COMM}, 8);
		put_n(KEY, 16);
		put_n(SADR, 6);
		check_frame;
		repeat (400) @(posedge CLK_SYS);
		reg_rd(`STF_REG_SEQ, d);
		chk(d, seq);
	end
endtask
////////////////////////////////////////
task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
endtask
// main sequence
initial begin
	repeat (3) @(posedge CLK_SYS);
	RST <= 1'b0;
	t_regs;
	t_data;
	t_priv;
	t_comm;
	report_and_stop;
end
// hang guard, far above the run length
initial begin
	#800000;
	mismatches = mismatches + 1;
	report_and_stop;
end
endmodule // tb_stf_framer
bind stf_framer stf_framer_sva chk (.CLK_SYS(CLK_SYS), .RST(RST), .ACT_START(ACT_START),
	.COMM_START(COMM_START), .BUSY(BUSY), .CRY_REQ(CRY_REQ), .CRY_SIGN(CRY_SIGN),
	.CRY_NONCE(CRY_NONCE), .CRY_DATA(CRY_DATA), .CRY_RESULT(CRY_RESULT),
	.CRY_DONE(CRY_DONE), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
	.TX_READY(TX_READY));
